// >>> csm_mem_model.sv
`timescale 1ns/1ns
// Far-side memory: takes the address at the edge where its enable is first
// seen low, then steps its beat counter as the burst strobes allow.
module csm_mem_model
(
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic dip_n_i,
  input wire logic final_n_i,
  input wire logic [7:0] addr_i,
  output logic [7:0] addr_o,
  output logic [3:0] beat_o
);
  logic ce_q;

  // Start idle, so the first enable edge is recognised.
  initial
  begin
    ce_q = 1'b0;
    addr_o = 8'h00;
    beat_o = 4'h0;
  end

  // The address is latched once, so the bus may move on after the enable edge.
  always @(posedge clk_i)
  begin
    ce_q <= !ce_n_i;
    if (!ce_n_i && !ce_q)
      addr_o <= addr_i;
    if (!final_n_i)
      beat_o <= 4'h0;
    else if (!dip_n_i)
      beat_o <= beat_o + 4'h1;
  end
endmodule : csm_mem_model

// >>> csm_pin_drive.sv
`timescale 1ns/1ns
// Decodes one select pin from its option fields and the live region state.
module csm_pin_drive
  import csm_pkg::*;
#(
  parameter int PIN_IDX = 0
)
(
  input wire csm_pin_cfg_t cfg_i,
  input wire logic [NUM_REGIONS-1:0] region_act_i,
  input wire logic write_i,
  input wire logic [NUM_LANES-1:0] byte_en_i,
  output logic assert_o,
  output logic alt_addr_o,
  output logic alt_dout_o
);

  // The region this pin's own decoder serves, when it has one.
  // Pins without a decoder point at the boot region so the index stays in range.
  localparam logic [2:0] OWN_REGION = ((PIN_IDX == BOOT_PIN) || !PIN_HAS_DEC[PIN_IDX]) ?
                                      REGION_BOOT : 3'(PIN_IDX);
  localparam logic HAS_DEC = PIN_HAS_DEC[PIN_IDX];

  // Reserved region codes leave a write or output enable pin idle rather than aliasing a region.
  always_comb
  begin
    assert_o = 1'b0;
    alt_addr_o = 1'b0;
    alt_dout_o = 1'b0;
    unique case (cfg_i.func)
      FN_CE:
      begin
        // The region field plays no part for a chip enable.
        if (HAS_DEC)
        begin
          assert_o = region_act_i[OWN_REGION];
        end
        else
        begin
          assert_o = 1'b0;
        end
      end
      FN_WE:
      begin
        if (cfg_i.region <= REGION_LAST)
        begin
          assert_o = region_act_i[cfg_i.region] & write_i &
                     byte_en_i[cfg_i.lane];
        end
      end
      FN_OE:
      begin
        if (cfg_i.region <= REGION_LAST)
        begin
          assert_o = region_act_i[cfg_i.region] & ~write_i;
        end
      end
      FN_ALT:
      begin
        alt_addr_o = cfg_i.ab_addr;
        alt_dout_o = ~cfg_i.ab_addr;
      end
    endcase
  end

endmodule : csm_pin_drive

// >>> csm_pin_map.sv
`timescale 1ns/1ns
// Function
// - Two-bit field picks chip, write, output enable.
// - Code 0b11 hands pin to alternate function.
// - Port A/B setting picks address or discrete.
// - Chip enable follows own decoder, ignores region.
// - Pins without decoders never assert as chip enables.
// - Write enable needs its selected byte enable.
// - Output enable ignores lane, covers all bytes.
// - Region field binds pin; codes six, seven reserved.
// - Keep per-region interface kind properties.
// - Reserved kind code keeps region select idle.
// - Only synchronous regions are ever pipelined.
// - Classify overlapped versus pipelined address timing.
// - Type one ends via DIP; two via final.
module csm_pin_map
  import csm_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire csm_pin_cfg_t [NUM_PINS-1:0] PIN_CFG_I,
  input wire logic [NUM_REGIONS-1:0][3:0] KIND_I,
  input wire logic ACC_VALID_I,
  input wire logic [NUM_REGIONS-1:0] ACC_HIT_I,
  input wire logic ACC_WRITE_I,
  input wire logic [NUM_LANES-1:0] BYTE_EN_I,
  input wire logic ADDR_PHASE_I,
  input wire logic DATA_PHASE_I,
  input wire logic BURST_ACTIVE_I,
  input wire logic BURST_LAST_I,
  output logic [NUM_PINS-1:0] SEL_N_O,
  output logic [NUM_PINS-1:0] ALT_ADDR_MODE_O,
  output logic [NUM_PINS-1:0] ALT_DOUT_MODE_O,
  output logic [NUM_REGIONS-1:0] REGION_PIPE_O,
  output logic [NUM_REGIONS-1:0] REGION_BURST_O,
  output logic [NUM_REGIONS-1:0] REGION_HOLDOFF_O,
  output logic [NUM_REGIONS-1:0] REGION_SYNC_OE_O,
  output logic OVERLAP_O,
  output logic PIPELINED_O,
  output logic ADDR_HOLD_O,
  output logic BURST_DIP_N_O,
  output logic FINAL_BEAT_N_O
);

  csm_state_t st_reg;
  csm_state_t st_next;
  csm_kind_t [NUM_REGIONS-1:0] kind;
  logic [NUM_REGIONS-1:0] kind_valid;
  logic [NUM_REGIONS-1:0] kind_pipe;
  logic [NUM_REGIONS-1:0] kind_b1;
  logic [NUM_REGIONS-1:0] kind_b2;
  logic [NUM_REGIONS-1:0] region_act;
  logic [NUM_PINS-1:0] pin_act;
  logic [NUM_PINS-1:0] pin_alt_addr;
  logic [NUM_PINS-1:0] pin_alt_dout;
  logic tgt_pipe;
  logic new_pipelined;
  logic new_overlap;
  logic new_hold;
  logic burst1_now;
  logic burst2_now;

  // Each region's kind code is decoded into its interface properties.
  genvar gr;
  generate
    for (gr = 0; gr < NUM_REGIONS; gr++)
    begin : g_region
      assign kind[gr] = csm_decode_kind(KIND_I[gr]);
      assign kind_valid[gr] = kind[gr].valid;
      assign kind_pipe[gr] = kind[gr].pipe;
      assign kind_b1[gr] = kind[gr].burst1;
      assign kind_b2[gr] = kind[gr].burst2;
    end
  endgenerate

  // A region counts as accessed only when its kind code is legal.
  assign region_act = {NUM_REGIONS{ACC_VALID_I}} & ACC_HIT_I & kind_valid;

  // One decoder per select pin.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_pin
      csm_pin_drive #(
        .PIN_IDX(gp)
      ) u_drive (
        .cfg_i(PIN_CFG_I[gp]),
        .region_act_i(region_act),
        .write_i(ACC_WRITE_I),
        .byte_en_i(BYTE_EN_I),
        .assert_o(pin_act[gp]),
        .alt_addr_o(pin_alt_addr[gp]),
        .alt_dout_o(pin_alt_dout[gp])
      );
    end
  endgenerate

  // Address timing against an access whose data is still outstanding.
  // An asynchronous target cannot latch the address, so instead of a
  // pipelined issue the bus is asked to hold the address until data ends.
  assign tgt_pipe = |(ACC_HIT_I & kind_pipe & kind_valid);
  assign new_overlap = st_reg.pending & ADDR_PHASE_I & DATA_PHASE_I;
  assign new_pipelined = st_reg.pending & ADDR_PHASE_I & ~DATA_PHASE_I &
                         tgt_pipe;
  assign new_hold = st_reg.pending & ADDR_PHASE_I & ~DATA_PHASE_I &
                    ~tgt_pipe;

  // Burst style of the region being accessed.
  assign burst1_now = |(region_act & kind_b1);
  assign burst2_now = |(region_act & kind_b2);

  // Next state: pins are registered active low so they cannot glitch.
  always_comb
  begin
    st_next = st_reg;
    st_next.sel_n = ~pin_act;
    st_next.alt_addr = pin_alt_addr;
    st_next.alt_dout = pin_alt_dout;
    st_next.pipe = kind_pipe & kind_valid;
    st_next.burst = (kind_b1 | kind_b2) & kind_valid;
    for (int r = 0; r < NUM_REGIONS; r++)
    begin
      st_next.holdoff[r] = kind[r].holdoff;
      st_next.sync_oe[r] = kind[r].sync_oe;
    end
    st_next.pending = (st_reg.pending & ~DATA_PHASE_I) |
                      (ADDR_PHASE_I & ~new_hold);
    st_next.overlap = new_overlap;
    st_next.pipelined = new_pipelined;
    st_next.addr_hold = new_hold;
    // Type one stays in progress until the last beat is under way.
    st_next.dip_n = ~(BURST_ACTIVE_I & burst1_now & ~BURST_LAST_I);
    // Type two marks only the final beat.
    st_next.final_n = ~(BURST_ACTIVE_I & burst2_now & BURST_LAST_I);
  end

  // Synchronous reset leaves every pin and strobe negated.
  always_ff @(posedge REF_CLK_I)
  begin
    if (SRST_I)
    begin
      st_reg <= '0;
      st_reg.sel_n <= '1;
      st_reg.dip_n <= 1'b1;
      st_reg.final_n <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign SEL_N_O = st_reg.sel_n;
  assign ALT_ADDR_MODE_O = st_reg.alt_addr;
  assign ALT_DOUT_MODE_O = st_reg.alt_dout;
  assign REGION_PIPE_O = st_reg.pipe;
  assign REGION_BURST_O = st_reg.burst;
  assign REGION_HOLDOFF_O = st_reg.holdoff;
  assign REGION_SYNC_OE_O = st_reg.sync_oe;
  assign OVERLAP_O = st_reg.overlap;
  assign PIPELINED_O = st_reg.pipelined;
  assign ADDR_HOLD_O = st_reg.addr_hold;
  assign BURST_DIP_N_O = st_reg.dip_n;
  assign FINAL_BEAT_N_O = st_reg.final_n;

  // Helper vectors seen only by the checks below.
  logic [NUM_PINS-1:0] chk_nodec_ce;
  logic [NUM_PINS-1:0] chk_alt;
  logic [NUM_PINS-1:0] chk_we_lane_off;
  logic [NUM_PINS-1:0] chk_bad_region;
  logic [NUM_PINS-1:0] chk_ce_bad_kind;
  logic [NUM_PINS-1:0] chk_oe_read;
  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      chk_nodec_ce[p] = (PIN_CFG_I[p].func == FN_CE) & ~PIN_HAS_DEC[p];
      chk_alt[p] = PIN_CFG_I[p].func == FN_ALT;
      chk_we_lane_off[p] = (PIN_CFG_I[p].func == FN_WE) &
                           ~BYTE_EN_I[PIN_CFG_I[p].lane];
      chk_bad_region[p] = (PIN_CFG_I[p].func != FN_CE) &
                          (PIN_CFG_I[p].region > REGION_LAST);
      chk_oe_read[p] = 1'b0;
      if ((PIN_CFG_I[p].func == FN_OE) && (PIN_CFG_I[p].region <= REGION_LAST))
      begin
        chk_oe_read[p] = region_act[PIN_CFG_I[p].region] & ~ACC_WRITE_I;
      end
      chk_ce_bad_kind[p] = 1'b0;
      if (p == BOOT_PIN)
      begin
        chk_ce_bad_kind[p] = (PIN_CFG_I[p].func == FN_CE) &
                             ~kind_valid[REGION_BOOT];
      end
      else if (PIN_HAS_DEC[p])
      begin
        chk_ce_bad_kind[p] = (PIN_CFG_I[p].func == FN_CE) & ~kind_valid[p];
      end
    end
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SRST_I);

  // A pin with no decoder never drives low as a chip enable.
  property p_nodec_ce_idle;
    (|chk_nodec_ce) |=> ((~SEL_N_O & $past(chk_nodec_ce)) == '0);
  endproperty
  a_nodec_ce_idle: assert property (p_nodec_ce_idle)
    else $error("Decoderless chip enable pin asserted.");

  // An alternate-function pin stays negated and reports its mode.
  property p_alt_release;
    (|chk_alt) |=> (((~SEL_N_O) & $past(chk_alt)) == '0) &&
      (((ALT_ADDR_MODE_O | ALT_DOUT_MODE_O) & $past(chk_alt)) == $past(chk_alt));
  endproperty
  a_alt_release: assert property (p_alt_release)
    else $error("Alternate pin not released from select use.");

  // Address mode follows the port A/B assignment of each alternate pin.
  property p_alt_mode;
    1'b1 |=> ALT_ADDR_MODE_O == $past(chk_alt & {NUM_PINS{1'b1}} &
      {PIN_CFG_I[12].ab_addr, PIN_CFG_I[11].ab_addr, PIN_CFG_I[10].ab_addr,
       PIN_CFG_I[9].ab_addr, PIN_CFG_I[8].ab_addr, PIN_CFG_I[7].ab_addr,
       PIN_CFG_I[6].ab_addr, PIN_CFG_I[5].ab_addr, PIN_CFG_I[4].ab_addr,
       PIN_CFG_I[3].ab_addr, PIN_CFG_I[2].ab_addr, PIN_CFG_I[1].ab_addr,
       PIN_CFG_I[0].ab_addr});
  endproperty
  a_alt_mode: assert property (p_alt_mode)
    else $error("Alternate pin mode does not follow assignment.");

  // A write enable whose lane is off stays negated.
  property p_we_lane;
    (|chk_we_lane_off) |=> ((~SEL_N_O & $past(chk_we_lane_off)) == '0);
  endproperty
  a_we_lane: assert property (p_we_lane)
    else $error("Write enable asserted without its byte enable.");

  // Reserved region codes bind any pin but a chip enable to nothing.
  property p_bad_region;
    (|chk_bad_region) |=> ((~SEL_N_O & $past(chk_bad_region)) == '0);
  endproperty
  a_bad_region: assert property (p_bad_region)
    else $error("Pin bound to a reserved region asserted.");

  // A chip enable of a region with a reserved kind code stays negated.
  property p_bad_kind;
    (|chk_ce_bad_kind) |=> ((~SEL_N_O & $past(chk_ce_bad_kind)) == '0);
  endproperty
  a_bad_kind: assert property (p_bad_kind)
    else $error("Chip enable asserted for a reserved kind.");

  // A boot chip enable follows its decoder hit one cycle later.
  property p_boot_ce;
    (PIN_CFG_I[BOOT_PIN].func == FN_CE && ACC_VALID_I &&
     ACC_HIT_I[REGION_BOOT] && kind_valid[REGION_BOOT])
      |=> !SEL_N_O[BOOT_PIN];
  endproperty
  a_boot_ce: assert property (p_boot_ce)
    else $error("Boot chip enable missed its decoder hit.");

  // No access in progress leaves every pin negated.
  property p_idle_negated;
    !ACC_VALID_I |=> (&SEL_N_O);
  endproperty
  a_idle_negated: assert property (p_idle_negated)
    else $error("Select pin asserted with no access.");

  // A pipelined issue is only ever reported for a synchronous target.
  property p_pipe_sync;
    PIPELINED_O |-> $past(tgt_pipe) && !ADDR_HOLD_O;
  endproperty
  a_pipe_sync: assert property (p_pipe_sync)
    else $error("Asynchronous region was pipelined.");

  // Address and data together while pending is overlap, not pipelining.
  sequence s_overlap_cause;
    st_reg.pending && ADDR_PHASE_I && DATA_PHASE_I;
  endsequence
  property p_overlap;
    s_overlap_cause |=> OVERLAP_O && !PIPELINED_O;
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("Overlapped access not flagged.");

  // Type two final-beat strobe lasts exactly one cycle per last beat.
  sequence s_last_beat2;
    BURST_ACTIVE_I && burst2_now && BURST_LAST_I;
  endsequence
  property p_final_beat;
    s_last_beat2 ##1 !(BURST_ACTIVE_I && burst2_now && BURST_LAST_I)
      |-> !FINAL_BEAT_N_O ##1 FINAL_BEAT_N_O;
  endproperty
  a_final_beat: assert property (p_final_beat)
    else $error("Final beat strobe wrong for type two burst.");

  // An output enable of a live region asserts on every read, whatever its lane.
  property p_oe_read;
    (|chk_oe_read) |=> ((SEL_N_O & $past(chk_oe_read)) == '0);
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("Output enable missed a read of its region.");

  // An address hold is only asked for a target that cannot latch the address.
  property p_hold_async;
    ADDR_HOLD_O |-> !$past(tgt_pipe) && !PIPELINED_O;
  endproperty
  a_hold_async: assert property (p_hold_async)
    else $error("Address hold asked for a pipelineable region.");

endmodule : csm_pin_map

// >>> csm_pin_map_tb.sv
`timescale 1ns/1ns
module csm_pin_map_tb;
  import csm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  csm_pin_cfg_t [NUM_PINS-1:0] cfg;
  logic [NUM_REGIONS-1:0][3:0] kind;
  logic vld, wr, aph, dph, bact, blast, armed, pnd;
  logic [NUM_REGIONS-1:0] hit, r_pipe, r_bst, r_hld, r_soe, e_pipe, e_bst, e_soe;
  logic [NUM_LANES-1:0] be;
  logic [NUM_PINS-1:0] sel_n, alt_a, alt_d, e_sel, e_alta, e_altd;
  logic ovl, ppl, ahd, dip_n, fin_n;
  logic [4:0] e_misc;
  logic [7:0] maddr, m_addr;
  logic [3:0] m_beat, b0;
  integer seed = 79;
  integer mismatches = 0;
  integer check_count = 0;

  csm_pin_map DUT (.REF_CLK_I(clk), .SRST_I(rst), .PIN_CFG_I(cfg), .KIND_I(kind),
    .ACC_VALID_I(vld), .ACC_HIT_I(hit), .ACC_WRITE_I(wr), .BYTE_EN_I(be),
    .ADDR_PHASE_I(aph), .DATA_PHASE_I(dph), .BURST_ACTIVE_I(bact),
    .BURST_LAST_I(blast), .SEL_N_O(sel_n), .ALT_ADDR_MODE_O(alt_a),
    .ALT_DOUT_MODE_O(alt_d), .REGION_PIPE_O(r_pipe), .REGION_BURST_O(r_bst),
    .REGION_HOLDOFF_O(r_hld), .REGION_SYNC_OE_O(r_soe), .OVERLAP_O(ovl),
    .PIPELINED_O(ppl), .ADDR_HOLD_O(ahd), .BURST_DIP_N_O(dip_n),
    .FINAL_BEAT_N_O(fin_n));

  csm_mem_model MEM (.clk_i(clk), .ce_n_i(sel_n[1]), .dip_n_i(dip_n),
    .final_n_i(fin_n), .addr_i(maddr), .addr_o(m_addr), .beat_o(m_beat));

  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 clk = ~clk;
  end

  // Kind code properties as {legal, sync, burst type 1, burst type 2}.
  function automatic logic [3:0] kdec(input logic [3:0] c);
    case (c)
      4'h0, 4'h1: kdec = 4'h8;
      4'h2, 4'h3: kdec = 4'hC;
      4'h5, 4'h7: kdec = 4'hE;
      4'h9, 4'hB: kdec = 4'hD;
      default: kdec = 4'h0;
    endcase
  endfunction : kdec

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      check_count++;
      if (g !== e)
      begin
        mismatches++;
        $display("Error %s expected %h seen %h", n, e, g);
      end
    end
  endtask : chk

  // Works out what the outputs must show one edge after the present inputs.
  task automatic predict();
    integer k, r, own;
    logic [3:0] d, tgt;
    logic [NUM_REGIONS-1:0] act;
    logic on;
    logic [2:0] rg;
    begin
      armed = 1'b1;
      tgt = 4'h0;
      for (r = 0; r < NUM_REGIONS; r++)
      begin
        d = kdec(kind[r]);
        act[r] = vld && hit[r] && d[3];
        e_pipe[r] = d[2];
        e_bst[r] = d[1] | d[0];
        e_soe[r] = kind[r] == 4'h3 || kind[r] == 4'h7 || kind[r] == 4'hB;
        if (hit[r] && d[3])
          tgt = d;
      end
      for (k = 0; k < NUM_PINS; k++)
      begin
        own = (k == BOOT_PIN) ? 0 : k;
        rg = cfg[k].region;
        case (cfg[k].func)
          FN_CE: on = ((k >= 1 && k <= 5) || k == BOOT_PIN) && act[own];
          FN_WE: on = rg < 3'h6 && act[rg] && wr && be[cfg[k].lane];
          FN_OE: on = rg < 3'h6 && act[rg] && !wr;
          default: on = 1'b0;
        endcase
        e_sel[k] = !on;
        e_alta[k] = cfg[k].func == FN_ALT && cfg[k].ab_addr;
        e_altd[k] = cfg[k].func == FN_ALT && !cfg[k].ab_addr;
      end
      e_misc = {aph && pnd && dph, aph && pnd && !dph && tgt[2],
        aph && pnd && !dph && !tgt[2], !(bact && !blast && vld && tgt[1]),
        !(bact && blast && vld && tgt[0])};
      pnd = aph || (pnd && !dph);
      if (rst)
      begin
        {e_sel, e_alta, e_altd, e_pipe, e_bst, e_soe} = {{NUM_PINS{1'b1}}, 44'h0};
        e_misc = 5'h03;
        pnd = 1'b0;
      end
    end
  endtask : predict

  // Waits for the falling edge and compares every output with the model.
  task automatic tick();
    begin
      @(negedge clk);
      if (armed)
      begin
        chk("sel_n", {19'h0, e_sel}, {19'h0, sel_n});
        chk("alt", {6'h0, e_alta, e_altd}, {6'h0, alt_a, alt_d});
        chk("kind", {8'h0, e_pipe, e_bst, e_pipe, e_soe}, {8'h0, r_pipe, r_bst, r_hld, r_soe});
        chk("timing", {27'h0, e_misc}, {27'h0, ovl, ppl, ahd, dip_n, fin_n});
      end
    end
  endtask : tick

  task automatic rnd();
    integer k;
    logic [31:0] v;
    begin
      for (k = 0; k < NUM_PINS; k++)
      begin
        v = $random(seed);
        cfg[k] = csm_pin_cfg_t'(v[7:0]);
      end
      for (k = 0; k < NUM_REGIONS; k++)
      begin
        v = $random(seed);
        kind[k] = v[3:0];
      end
      v = $random(seed);
      hit = 6'h01 << (v[7:0] % 8'd6);
      {blast, bact, be, wr, vld} = v[15:8];
      {dph, aph} = v[25:24];
      maddr = v[23:16];
    end
  endtask : rnd

  // Two addresses to region one; the second comes with or without data.
  task automatic pipe_seq(input logic [3:0] code, input logic d2);
    begin
      tick();
      {kind[1], hit, vld, aph, dph} = {code, 6'h02, 3'b110};
      predict();
      tick();
      dph = d2;
      predict();
      tick();
      {aph, dph} = 2'b01;
      predict();
      tick();
      {vld, dph} = 2'b00;
      predict();
    end
  endtask : pipe_seq

  // Three beats to region one, the last flagged; the memory sees the enable.
  task automatic burst_seq(input logic [3:0] code);
    begin
      tick();
      {kind[1], hit, vld, bact, blast, maddr} = {code, 6'h02, 3'b110, 8'h11};
      predict();
      tick();
      maddr = {4'h3, code};
      predict();
      tick();
      {blast, maddr} = {1'b1, 8'h22};
      predict();
      tick();
      {vld, bact, blast} = 3'b000;
      predict();
      chk("mem_addr", {28'h3, code}, {24'h0, m_addr});
    end
  endtask : burst_seq

  task automatic conclude();
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask : conclude

  // Cuts a hang short well past the expected few hundred cycles.
  initial
  begin
    #(20 * 5000);
    mismatches++;
    conclude();
  end

  // Reset, random traffic, a second reset, then directed timing cases.
  initial
  begin
    {cfg, kind, vld, hit, wr, be, aph, dph, bact, blast, maddr} = '0;
    {armed, pnd} = 2'b00;
    tick();
    predict();
    tick();
    rst = 1'b0;
    rnd();
    predict();
    repeat (400)
    begin
      tick();
      rnd();
      predict();
    end
    tick();
    rst = 1'b1;
    predict();
    tick();
    rst = 1'b0;
    {cfg, kind, vld, bact, blast} = '0;
    for (int k = 0; k < NUM_PINS; k++)
      cfg[k].func = (k == 1) ? FN_CE : FN_ALT;
    predict();
    pipe_seq(4'h2, 1'b0);
    pipe_seq(4'h0, 1'b0);
    pipe_seq(4'h3, 1'b1);
    b0 = m_beat;
    burst_seq(4'h5);
    chk("mem_beat", {28'h0, b0 + 4'h2}, {28'h0, m_beat});
    burst_seq(4'h9);
    tick();
    chk("mem_beat", 32'h0, {28'h0, m_beat});
    conclude();
  end
endmodule : csm_pin_map_tb

// >>> csm_pkg.sv
package csm_pkg;

  // Pin and region counts; pin index 12 is the boot select pin.
  localparam int NUM_PINS = 13;
  localparam int NUM_REGIONS = 6;
  localparam int NUM_LANES = 4;
  localparam int BOOT_PIN = 12;

  // Pins that own a base-address decoder: the boot pin and pins one to five.
  localparam logic [NUM_PINS-1:0] PIN_HAS_DEC = 13'h103E;

  // Highest legal region code; codes above it are reserved.
  localparam logic [2:0] REGION_BOOT = 3'h0;
  localparam logic [2:0] REGION_LAST = 3'h5;

  // Pin function encodings.
  typedef enum logic [1:0] {
    FN_CE = 2'h0,
    FN_WE = 2'h1,
    FN_OE = 2'h2,
    FN_ALT = 2'h3
  } csm_func_t;

  // Interface kind codes.
  localparam logic [3:0] KIND_ASYNC_FAST = 4'h0;
  localparam logic [3:0] KIND_ASYNC_SLOW = 4'h1;
  localparam logic [3:0] KIND_SYNC_AOE = 4'h2;
  localparam logic [3:0] KIND_SYNC_SOE = 4'h3;
  localparam logic [3:0] KIND_BURST1_AOE = 4'h5;
  localparam logic [3:0] KIND_BURST1_SOE = 4'h7;
  localparam logic [3:0] KIND_BURST2_AOE = 4'h9;
  localparam logic [3:0] KIND_BURST2_SOE = 4'hB;

  // Per-pin option fields.
  typedef struct packed {
    csm_func_t func;
    logic [1:0] lane;
    logic [2:0] region;
    logic ab_addr;
  } csm_pin_cfg_t;

  // Properties that an interface kind code stands for.
  typedef struct packed {
    logic valid;
    logic sync;
    logic pipe;
    logic holdoff;
    logic sync_oe;
    logic burst1;
    logic burst2;
  } csm_kind_t;

  // State of the top module.
  typedef struct packed {
    logic [NUM_PINS-1:0] sel_n;
    logic [NUM_PINS-1:0] alt_addr;
    logic [NUM_PINS-1:0] alt_dout;
    logic [NUM_REGIONS-1:0] pipe;
    logic [NUM_REGIONS-1:0] burst;
    logic [NUM_REGIONS-1:0] holdoff;
    logic [NUM_REGIONS-1:0] sync_oe;
    logic pending;
    logic overlap;
    logic pipelined;
    logic addr_hold;
    logic dip_n;
    logic final_n;
  } csm_state_t;

  // Reserved codes map to all-zero properties with valid low.
  function automatic csm_kind_t csm_decode_kind(input logic [3:0] code);
    csm_kind_t k;
    k = '0;
    k.valid = 1'b1;
    unique case (code)
      KIND_ASYNC_FAST, KIND_ASYNC_SLOW: k.sync = 1'b0;
      KIND_SYNC_AOE, KIND_SYNC_SOE: k.sync = 1'b1;
      KIND_BURST1_AOE, KIND_BURST1_SOE: k.burst1 = 1'b1;
      KIND_BURST2_AOE, KIND_BURST2_SOE: k.burst2 = 1'b1;
      default: k.valid = 1'b0;
    endcase
    k.sync = k.sync | k.burst1 | k.burst2;
    k.pipe = k.sync;
    k.holdoff = k.sync;
    // Only the synchronous-OE variants get a clocked one-cycle enable; bit 0 alone
    // would also mark the asynchronous-OE burst codes.
    k.sync_oe = (code == KIND_SYNC_SOE) | (code == KIND_BURST1_SOE) |
                (code == KIND_BURST2_SOE);
    return k;
  endfunction : csm_decode_kind

endpackage : csm_pkg
